/* verilog/asdec_pkg.sv */
// Package of constants and types for the accumulator store decoder.
// Summary of operation
// - Pair load puts register B in upper nibble, accumulator in lower, one cycle.
// - Interrupt control load copies accumulator into interrupt control register one.
// - Wakeup load zero copies accumulator into wakeup control register zero.
// - Wakeup load one copies accumulator into wakeup control register one.
// - Wakeup load two copies accumulator into wakeup control register two.
// - Memory store writes accumulator to the nibble the data pointer selects.
// - Memory store replaces file select with its XOR against immediate j.
// - Clock control load copies accumulator into the clock control register.
// - Pull-up load copies accumulator into pull-up control register zero.
package asdec_pkg;

   // Instruction codes, ten bits wide; the store code gives only its upper six bits.
   localparam logic [9:0] OP_LOAD_PAIR_FROM_ACC_B = 10'h01A;
   localparam logic [9:0] OP_LOAD_INT_CTRL_ONE = 10'h217;
   localparam logic [9:0] OP_LOAD_WAKE_CTRL_ZERO = 10'h21B;
   localparam logic [9:0] OP_LOAD_WAKE_CTRL_ONE = 10'h214;
   localparam logic [9:0] OP_LOAD_WAKE_CTRL_TWO = 10'h215;
   localparam logic [9:0] OP_LOAD_CLOCK_CTRL = 10'h216;
   localparam logic [9:0] OP_LOAD_PULLUP_CTRL_ZERO = 10'h22D;
   localparam logic [5:0] OP_STORE_MEM_XOR_FILE_HI = 6'h2B;

   // Register read offsets on the plain register port.
   localparam logic [3:0] REG_PAIR_LO = 4'h0;
   localparam logic [3:0] REG_PAIR_HI = 4'h1;
   localparam logic [3:0] REG_INT_CTRL_ONE = 4'h2;
   localparam logic [3:0] REG_WAKE_CTRL_ZERO = 4'h3;
   localparam logic [3:0] REG_WAKE_CTRL_ONE = 4'h4;
   localparam logic [3:0] REG_WAKE_CTRL_TWO = 4'h5;
   localparam logic [3:0] REG_CLOCK_CTRL = 4'h6;
   localparam logic [3:0] REG_PULLUP_CTRL_ZERO = 4'h7;
   localparam logic [3:0] REG_FILE_SELECT = 4'h8;
   localparam logic [3:0] REG_MEM_DATA = 4'h9;

   // Reset values.
   localparam logic [3:0] RST_NIBBLE = 4'h0;
   localparam logic [7:0] RST_PAIR = 8'h00;

   // Instruction issue bundle from the core.
   typedef struct packed {
      logic valid;
      logic [9:0] code;
      logic [3:0] acc;
      logic [3:0] reg_b;
   } asdec_insn_t;

   // Destination registers as one bundle.
   typedef struct packed {
      logic [7:0] pair;
      logic [3:0] interrupt_ctrl_one;
      logic [3:0] wake_ctrl_zero;
      logic [3:0] wake_ctrl_one;
      logic [3:0] wake_ctrl_two;
      logic [3:0] clock_ctrl_reg;
      logic [3:0] pullup_ctrl_zero;
      logic [3:0] file_select;
   } asdec_dest_t;

endpackage : asdec_pkg

/* verilog/asdec_data_mem.sv */
// Nibble-wide data memory held in flip-flops.
`timescale 1ns/100ps
module asdec_data_mem #(
   parameter int ADDR_W = 6
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [3:0] wr_data,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [3:0] rd_data
);
   import asdec_pkg::*;

   localparam int DEPTH = 1 << ADDR_W;

   logic [3:0] mem_ff [DEPTH];
   logic [3:0] nxt_mem [DEPTH];

   // Next contents: only the addressed nibble changes.
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         nxt_mem[i] = mem_ff[i];
      end
      if (wr_en) begin
         nxt_mem[wr_addr] = wr_data;
      end
   end

   // Memory keeps its contents through reset, as a real RAM would.
   always_ff @(posedge clock) begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_ff[i] <= nxt_mem[i];
      end
   end

   // Read is asynchronous; the caller registers the result.
   assign rd_data = mem_ff[rd_addr];

endmodule : asdec_data_mem

/* verilog/asdec_top.sv */
// Execution logic for the accumulator transfer and memory store instructions.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module asdec_top #(
   parameter int ADDR_W = 6
) (
   input wire logic clock,
   input wire logic rst_n,
   input asdec_pkg::asdec_insn_t insn,
   input wire logic [ADDR_W-1:0] data_pointer,
   output logic insn_hit,
   output logic carry_flag_we,
   output logic skip_next,
   output asdec_pkg::asdec_dest_t dest,
   input wire logic [3:0] reg_addr,
   input wire logic [3:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [3:0] reg_rdata
);
   import asdec_pkg::*;

   typedef enum logic [3:0] {
      ASDEC_OP_NONE = 4'h0,
      ASDEC_OP_PAIR = 4'h1,
      ASDEC_OP_INT = 4'h2,
      ASDEC_OP_WAKE0 = 4'h3,
      ASDEC_OP_WAKE1 = 4'h4,
      ASDEC_OP_WAKE2 = 4'h5,
      ASDEC_OP_CLOCK = 4'h6,
      ASDEC_OP_PULLUP = 4'h7,
      ASDEC_OP_STORE = 4'h8
   } asdec_op_t;

   // Maps an instruction code to its operation class.
   function automatic asdec_op_t decode_op(input logic [9:0] code);
      asdec_op_t op;
      op = ASDEC_OP_NONE;
      if (code[9:4] == OP_STORE_MEM_XOR_FILE_HI) begin
         op = ASDEC_OP_STORE;
      end else begin
         unique case (code)
            OP_LOAD_PAIR_FROM_ACC_B: op = ASDEC_OP_PAIR;
            OP_LOAD_INT_CTRL_ONE: op = ASDEC_OP_INT;
            OP_LOAD_WAKE_CTRL_ZERO: op = ASDEC_OP_WAKE0;
            OP_LOAD_WAKE_CTRL_ONE: op = ASDEC_OP_WAKE1;
            OP_LOAD_WAKE_CTRL_TWO: op = ASDEC_OP_WAKE2;
            OP_LOAD_CLOCK_CTRL: op = ASDEC_OP_CLOCK;
            OP_LOAD_PULLUP_CTRL_ZERO: op = ASDEC_OP_PULLUP;
            default: op = ASDEC_OP_NONE;
         endcase
      end
      return op;
   endfunction : decode_op

   asdec_op_t op;
   asdec_dest_t dest_ff;
   asdec_dest_t nxt_dest;
   logic [3:0] rdata_ff;
   logic [3:0] nxt_rdata;
   logic mem_wr;
   logic [3:0] mem_rd_data;

   // Every instruction of the group finishes in the cycle it is issued.
   assign op = insn.valid ? decode_op(insn.code) : ASDEC_OP_NONE;
   assign insn_hit = (op != ASDEC_OP_NONE);
   assign carry_flag_we = 1'b0;
   assign skip_next = 1'b0;
   assign mem_wr = (op == ASDEC_OP_STORE);

   // Destination register updates; a software write to file select loses to a store in the same cycle.
   always_comb begin
      nxt_dest = dest_ff;
      if (reg_wr && reg_addr == REG_FILE_SELECT) begin
         nxt_dest.file_select = reg_wdata;
      end
      unique case (op)
         ASDEC_OP_PAIR: nxt_dest.pair = {insn.reg_b, insn.acc};
         ASDEC_OP_INT: nxt_dest.interrupt_ctrl_one = insn.acc;
         ASDEC_OP_WAKE0: nxt_dest.wake_ctrl_zero = insn.acc;
         ASDEC_OP_WAKE1: nxt_dest.wake_ctrl_one = insn.acc;
         ASDEC_OP_WAKE2: nxt_dest.wake_ctrl_two = insn.acc;
         ASDEC_OP_CLOCK: nxt_dest.clock_ctrl_reg = insn.acc;
         ASDEC_OP_PULLUP: nxt_dest.pullup_ctrl_zero = insn.acc;
         ASDEC_OP_STORE: nxt_dest.file_select = dest_ff.file_select ^ insn.code[3:0];
         ASDEC_OP_NONE: nxt_dest = nxt_dest;
      endcase
   end

   // Destination registers with synchronous reset.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dest_ff <= '{pair: RST_PAIR, default: RST_NIBBLE};
      end else begin
         dest_ff <= nxt_dest;
      end
   end

   assign dest = dest_ff;

   // Register read mux; unmapped offsets read zero.
   always_comb begin
      nxt_rdata = 4'h0;
      if (reg_rd) begin
         unique case (reg_addr)
            REG_PAIR_LO: nxt_rdata = dest_ff.pair[3:0];
            REG_PAIR_HI: nxt_rdata = dest_ff.pair[7:4];
            REG_INT_CTRL_ONE: nxt_rdata = dest_ff.interrupt_ctrl_one;
            REG_WAKE_CTRL_ZERO: nxt_rdata = dest_ff.wake_ctrl_zero;
            REG_WAKE_CTRL_ONE: nxt_rdata = dest_ff.wake_ctrl_one;
            REG_WAKE_CTRL_TWO: nxt_rdata = dest_ff.wake_ctrl_two;
            REG_CLOCK_CTRL: nxt_rdata = dest_ff.clock_ctrl_reg;
            REG_PULLUP_CTRL_ZERO: nxt_rdata = dest_ff.pullup_ctrl_zero;
            REG_FILE_SELECT: nxt_rdata = dest_ff.file_select;
            REG_MEM_DATA: nxt_rdata = mem_rd_data;
            default: nxt_rdata = 4'h0;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata_ff <= 4'h0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

   // Data memory, written by the store and readable at the current pointer.
   asdec_data_mem #(
      .ADDR_W(ADDR_W)
   ) u_mem (
      .clock(clock),
      .rst_n(rst_n),
      .wr_en(mem_wr),
      .wr_addr(data_pointer),
      .wr_data(insn.acc),
      .rd_addr(data_pointer),
      .rd_data(mem_rd_data)
   );

endmodule : asdec_top

/* verification/asdec_props.sv */
// Checker of the accumulator store decoder outputs.
`timescale 1ns/100ps
module asdec_props #(
   parameter int ADDR_W = 6
) (
   input wire logic clock,
   input wire logic rst_n,
   input asdec_pkg::asdec_insn_t insn,
   input wire logic [ADDR_W-1:0] data_pointer,
   input wire logic insn_hit,
   input wire logic carry_flag_we,
   input wire logic skip_next,
   input asdec_pkg::asdec_dest_t dest,
   input wire logic [3:0] reg_addr,
   input wire logic [3:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [3:0] reg_rdata
);
   import asdec_pkg::*;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // Short aliases keep each property within two lines.
   wire v = insn.valid;
   wire [9:0] c = insn.code;
   wire [3:0] a = insn.acc;
   wire [3:0] imm = insn.code[3:0];
   // Each load must land in its own field at the very next cycle.
   a_pair_load: assert property (v && c == OP_LOAD_PAIR_FROM_ACC_B
      |=> dest.pair == {$past(insn.reg_b), $past(a)}) else $error("bad pair");
   a_int_load: assert property (v && c == OP_LOAD_INT_CTRL_ONE
      |=> dest.interrupt_ctrl_one == $past(a)) else $error("bad int ctrl");
   a_wake_zero: assert property (v && c == OP_LOAD_WAKE_CTRL_ZERO
      |=> dest.wake_ctrl_zero == $past(a)) else $error("bad wake zero");
   a_wake_one: assert property (v && c == OP_LOAD_WAKE_CTRL_ONE
      |=> dest.wake_ctrl_one == $past(a)) else $error("bad wake one");
   a_wake_two: assert property (v && c == OP_LOAD_WAKE_CTRL_TWO
      |=> dest.wake_ctrl_two == $past(a)) else $error("bad wake two");
   a_clock_load: assert property (v && c == OP_LOAD_CLOCK_CTRL
      |=> dest.clock_ctrl_reg == $past(a)) else $error("bad clock ctrl");
   a_pullup_load: assert property (v && c == OP_LOAD_PULLUP_CTRL_ZERO
      |=> dest.pullup_ctrl_zero == $past(a)) else $error("bad pullup");
   a_store_xor: assert property (v && c[9:4] == OP_STORE_MEM_XOR_FILE_HI
      |=> dest.file_select == ($past(dest.file_select) ^ $past(imm))) else $error("bad file xor");
   a_no_carry: assert property (!carry_flag_we && !skip_next) else $error("carry or skip");
   // The hit flag must follow the issue strobe; a store is always one of the group.
   a_hit_store: assert property (v && c[9:4] == OP_STORE_MEM_XOR_FILE_HI
      |-> insn_hit) else $error("store not taken");
   a_hit_issue: assert property (insn_hit |-> v) else $error("hit without issue");
   // Read data must drop back to zero when no read was strobed, so stale data never lingers.
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 4'h0) else $error("stale read data");
endmodule : asdec_props
bind asdec_top asdec_props #(.ADDR_W(ADDR_W)) u_asdec_props (.clock(clock), .rst_n(rst_n), .insn(insn),
   .data_pointer(data_pointer), .insn_hit(insn_hit), .carry_flag_we(carry_flag_we), .skip_next(skip_next),
   .dest(dest), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

/* verification/asdec_tb_top.sv */
// Self-checking bench for the accumulator store decoder.
`timescale 1ns/100ps
module asdec_tb_top;
   import asdec_pkg::*;
   logic clock = 0;
   logic rst_n = 0;
   asdec_insn_t insn = '0;
   logic [5:0] dp = '0;
   logic [3:0] reg_addr = '0;
   logic [3:0] reg_wdata = '0;
   logic reg_wr = 0;
   logic reg_rd = 0;
   logic [3:0] reg_rdata;
   asdec_dest_t dest;
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [9:0] codes [6] = '{OP_LOAD_INT_CTRL_ONE, OP_LOAD_WAKE_CTRL_ZERO, OP_LOAD_WAKE_CTRL_ONE,
      OP_LOAD_WAKE_CTRL_TWO, OP_LOAD_CLOCK_CTRL, OP_LOAD_PULLUP_CTRL_ZERO};
   logic [3:0] offs [6] = '{REG_INT_CTRL_ONE, REG_WAKE_CTRL_ZERO, REG_WAKE_CTRL_ONE,
      REG_WAKE_CTRL_TWO, REG_CLOCK_CTRL, REG_PULLUP_CTRL_ZERO};
   asdec_top u_asdec_top (.clock(clock), .rst_n(rst_n), .insn(insn), .data_pointer(dp), .insn_hit(),
      .carry_flag_we(), .skip_next(), .dest(dest), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   // Free-running 100 MHz clock and a cycle ceiling that catches a hang.
   always #5 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         stop_test;
      end
   end
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Issue leaves valid high, so consecutive calls run back to back.
   task automatic exec(input logic [9:0] code, input logic [3:0] a, input logic [3:0] b);
      @(posedge clock);
      insn <= '{1'b1, code, a, b};
   endtask : exec
   task automatic idle;
      @(posedge clock);
      insn.valid <= 1'b0;
   endtask : idle
   // Read data is only valid in the cycle after the strobe, so it is sampled just after that edge.
   task automatic rd(input logic [3:0] addr, input logic [3:0] exp);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= addr;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rd
   task automatic stop_test;
      if (num_errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   // Main sequence: loads, then a run of stores, then readback of memory.
   initial begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rd(REG_PAIR_HI, RST_NIBBLE);
      exec(OP_LOAD_PAIR_FROM_ACC_B, 4'h5, 4'hA);
      idle;
      rd(REG_PAIR_LO, 4'h5);
      rd(REG_PAIR_HI, 4'hA);
      // A code outside the group must leave the pair alone; only its low nibble is read back.
      exec(10'h01B, 4'h7, 4'h7);
      idle;
      rd(REG_PAIR_LO, 4'h5);
      for (int i = 0; i < 6; i++) exec(codes[i], 4'(i + 9), 4'h3);
      idle;
      for (int i = 0; i < 6; i++) rd(offs[i], 4'(i + 9));
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= REG_FILE_SELECT;
      reg_wdata <= 4'h6;
      @(posedge clock);
      reg_wr <= 1'b0;
      for (int j = 0; j < 15; j++) begin
         exec({OP_STORE_MEM_XOR_FILE_HI, 4'(j)}, ~4'(j), 4'h0);
         dp <= 6'(j);
      end
      idle;
      rd(REG_FILE_SELECT, 4'h9);
      // A store and a software write to file select in one cycle: the store wins.
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= REG_FILE_SELECT;
      reg_wdata <= 4'h0;
      insn <= '{1'b1, {OP_STORE_MEM_XOR_FILE_HI, 4'h3}, 4'h0, 4'h0};
      dp <= 6'h3F;
      @(posedge clock);
      reg_wr <= 1'b0;
      insn.valid <= 1'b0;
      rd(REG_FILE_SELECT, 4'hA);
      for (int j = 0; j < 15; j++) begin
         @(posedge clock);
         dp <= 6'(j);
         rd(REG_MEM_DATA, ~4'(j));
      end
      rd(4'hF, 4'h0);
      stop_test;
   end
endmodule : asdec_tb_top
